// [inc/flash_erase_regs.svh]
`ifndef FLASH_ERASE_REGS_SVH
`define FLASH_ERASE_REGS_SVH

// opcodes seen on the serial input
`define OP_BLOCK_ERASE_4K   8'h20
`define OP_BLOCK_ERASE_32K  8'h52
`define OP_BLOCK_ERASE_64K  8'hD8
`define OP_CHIP_ERASE_A     8'h60
`define OP_CHIP_ERASE_B     8'hC7
`define OP_WRITE_ENABLE     8'h06
`define OP_WRITE_DISABLE    8'h04

// frame layout: one opcode byte, three address bytes
`define OPCODE_BITS         6'h08
`define FRAME_BITS          6'h20
`define LAST_FRAME_BIT      6'h1F
`define LAST_OPCODE_BIT     6'h07

// low address bits ignored per block size
`define IGNORE_BITS_4K      12
`define IGNORE_BITS_32K     15
`define IGNORE_BITS_64K     16

// sector select inside the address
`define SECTOR_COUNT        16
`define SECTOR_MSB          19
`define SECTOR_LSB          16

// reset values
`define SECTOR_PROT_RESET   16'hFFFF

// timing: clock rate and erase times (plain defaults)
`define CLOCK_MHZ           250
`define BLOCK_ERASE_TIME_4K_US   100000
`define BLOCK_ERASE_TIME_32K_US  500000
`define BLOCK_ERASE_TIME_64K_US  1000000
`define CHIP_ERASE_TIME_US       4000000

`endif

// [inc/flash_erase_pkg.sv]
package flash_erase_pkg;

  // erase region sizes
  typedef enum logic [1:0] {
    SIZE_4K,
    SIZE_32K,
    SIZE_64K,
    SIZE_CHIP
  } erase_size_e;

  // sequencer states
  typedef enum logic {
    ST_IDLE,
    ST_ERASING
  } seq_state_e;

  // one captured serial frame
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [5:0]  bits;
    logic        full;
  } frame_s;

  // erase command driven to the array
  typedef struct packed {
    logic        active;
    erase_size_e size;
    logic [23:0] base;
  } erase_cmd_s;

endpackage : flash_erase_pkg

// [src/flash_erase_seq.sv]
`timescale 1ns/1ns
`default_nettype none
`include "flash_erase_regs.svh"

// Contract
// - opcodes 20h/52h/D8h pick 4K/32K/64K erase
// - block erase needs the write enable latch
// - three address bytes, later bytes discarded
// - erase starts at chip select release, timed
// - low address bits ignored per block size
// - short address or misaligned release aborts
// - protected sector skips erase, back to idle
// - block erase abort clears the latch
// - busy while erasing, latch cleared before end
// - erase failure sets the error flag
// - 60h or C7h erase whole array
// - chip erase needs the write enable latch
// - partial opcode or misaligned release: no erase
// - any protected sector blocks chip erase
// - rejected chip erase clears the latch
// - guarded commands refused without the latch
// - opcode 06h sets latch at release
// - opcode 04h clears latch at release
// - bad enable/disable frame leaves latch alone
// - bytes after single-byte opcodes ignored
// - sector protection bits reset to one
module flash_erase_seq #(
  parameter int unsigned BLK4_ERASE_CYCLES  =
    `BLOCK_ERASE_TIME_4K_US * `CLOCK_MHZ,
  parameter int unsigned BLK32_ERASE_CYCLES =
    `BLOCK_ERASE_TIME_32K_US * `CLOCK_MHZ,
  parameter int unsigned BLK64_ERASE_CYCLES =
    `BLOCK_ERASE_TIME_64K_US * `CLOCK_MHZ,
  parameter int unsigned CHIP_ERASE_CYCLES  =
    `CHIP_ERASE_TIME_US * `CLOCK_MHZ
) (
  input  wire logic        clock_i,      // system clock, 250 MHz
  input  wire logic        resetn_i,     // sync reset, active low
  input  wire logic        sclk_i,       // serial clock from host
  input  wire logic        cs_n_i,       // chip select, active low
  input  wire logic        si_i,         // serial data in
  input  wire logic [15:0] prot_set_i,   // per-sector protect pulse
  input  wire logic [15:0] prot_clr_i,   // per-sector unprotect pulse
  input  wire logic [15:0] lockdown_i,   // per-sector lockdown level
  input  wire logic        erase_fail_i, // array verify failure
  output logic             busy_o,       // erase in progress
  output logic             write_enable_latch_o,       // latch state
  output logic             erase_program_error_flag_o, // last erase failed
  output logic [15:0]      sector_prot_o,              // protection bits
  output flash_erase_pkg::erase_cmd_s erase_cmd_o      // array command
);

  // link domain state
  logic                    first_q;
  logic [5:0]              bit_cnt_q;
  logic [31:0]             shift_q;
  logic [7:0]              opcode_q;
  logic                    full_q;
  flash_erase_pkg::frame_s link_frame;

  // system domain state
  logic [2:0]              cs_sync_q;
  logic                    cs_level_q;
  logic                    rel_q;
  flash_erase_pkg::frame_s frame_q;
  flash_erase_pkg::seq_state_e state_q;
  logic [31:0]             timer_q;
  logic                    wel_q;
  logic                    epe_q;
  logic [15:0]             sector_prot_q;
  flash_erase_pkg::erase_cmd_s cmd_q;

  // decode terms
  logic                    cs_rise;
  logic                    op_ok;
  logic                    aligned;
  logic                    is_blk;
  logic                    is_chip;
  logic                    is_wren;
  logic                    is_wrdi;
  logic                    blk_prot;
  logic                    any_prot;
  logic                    idle_rel;
  logic                    blk_go;
  logic                    blk_abort;
  logic                    chip_go;
  logic                    chip_abort;
  logic                    wren_go;
  logic                    wrdi_go;
  logic                    start;
  flash_erase_pkg::erase_size_e blk_size;
  logic [3:0]              sector;

  // block base: clear ignored low address bits
  function automatic logic [23:0] block_base(
    input logic [23:0]                  a,
    input flash_erase_pkg::erase_size_e s
  );
    logic [23:0] mask;
    mask = 24'h00_0000;
    unique case (s)
      flash_erase_pkg::SIZE_4K:  mask = ~((24'h00_0001 << `IGNORE_BITS_4K)
                                           - 24'h00_0001);
      flash_erase_pkg::SIZE_32K: mask = ~((24'h00_0001 << `IGNORE_BITS_32K)
                                           - 24'h00_0001);
      flash_erase_pkg::SIZE_64K: mask = ~((24'h00_0001 << `IGNORE_BITS_64K)
                                           - 24'h00_0001);
      flash_erase_pkg::SIZE_CHIP: mask = 24'h00_0000;
    endcase
    return a & mask;
  endfunction : block_base

  // erase duration for a region size, less one
  function automatic logic [31:0] erase_cycles(
    input flash_erase_pkg::erase_size_e s
  );
    logic [31:0] n;
    n = 32'h0000_0000;
    unique case (s)
      flash_erase_pkg::SIZE_4K:   n = 32'(BLK4_ERASE_CYCLES);
      flash_erase_pkg::SIZE_32K:  n = 32'(BLK32_ERASE_CYCLES);
      flash_erase_pkg::SIZE_64K:  n = 32'(BLK64_ERASE_CYCLES);
      flash_erase_pkg::SIZE_CHIP: n = 32'(CHIP_ERASE_CYCLES);
    endcase
    return n - 32'h0000_0001;
  endfunction : erase_cycles

  // ---------------- link domain ----------------

  // frame start flag, set while chip select is high
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  always_ff @(posedge sclk_i) begin
    if (first_q) begin
      bit_cnt_q <= 6'h01;
    end else begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  // capture 32 bits, discard the rest
  always_ff @(posedge sclk_i) begin
    if (first_q) begin
      shift_q <= {31'h0000_0000, si_i};
      full_q  <= 1'b0;
    end else if (!full_q) begin
      shift_q <= {shift_q[30:0], si_i};
      full_q  <= (bit_cnt_q == `LAST_FRAME_BIT);
    end
  end

  // opcode held once the first byte lands
  always_ff @(posedge sclk_i) begin
    if (!first_q && bit_cnt_q == `LAST_OPCODE_BIT) begin
      opcode_q <= {shift_q[6:0], si_i};
    end
  end

  // frame as seen when chip select rises
  always_comb begin
    link_frame.opcode = opcode_q;
    link_frame.addr   = shift_q[23:0];
    link_frame.bits   = bit_cnt_q;
    link_frame.full   = full_q;
  end

  // ---------------- system domain ----------------

  // chip select through three flops, agreement of last two counts
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cs_sync_q  <= 3'h7;
      cs_level_q <= 1'b1;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], cs_n_i};
      if (cs_sync_q[1] == cs_sync_q[2]) begin
        cs_level_q <= cs_sync_q[2];
      end
    end
  end

  assign cs_rise = !cs_level_q && cs_sync_q[1] && cs_sync_q[2];

  // capture frame at release; link regs are frozen then
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rel_q   <= 1'b0;
      frame_q <= '0;
    end else begin
      rel_q <= cs_rise;
      if (cs_rise) begin
        frame_q <= link_frame;
      end
    end
  end

  // command decode on the captured frame
  always_comb begin
    sector   = frame_q.addr[`SECTOR_MSB:`SECTOR_LSB];
    op_ok    = frame_q.full || (frame_q.bits >= `OPCODE_BITS);
    aligned  = (frame_q.bits[2:0] == 3'h0);
    is_blk   = (frame_q.opcode == `OP_BLOCK_ERASE_4K)  ||
               (frame_q.opcode == `OP_BLOCK_ERASE_32K) ||
               (frame_q.opcode == `OP_BLOCK_ERASE_64K);
    is_chip  = (frame_q.opcode == `OP_CHIP_ERASE_A) ||
               (frame_q.opcode == `OP_CHIP_ERASE_B);
    is_wren  = (frame_q.opcode == `OP_WRITE_ENABLE);
    is_wrdi  = (frame_q.opcode == `OP_WRITE_DISABLE);
    blk_size = flash_erase_pkg::SIZE_4K;
    if (frame_q.opcode == `OP_BLOCK_ERASE_32K) begin
      blk_size = flash_erase_pkg::SIZE_32K;
    end else if (frame_q.opcode == `OP_BLOCK_ERASE_64K) begin
      blk_size = flash_erase_pkg::SIZE_64K;
    end
    blk_prot = sector_prot_q[sector] || lockdown_i[sector];
    any_prot = |(sector_prot_q | lockdown_i);
    idle_rel = rel_q && (state_q == flash_erase_pkg::ST_IDLE) && op_ok;
    // block erase only with latch, full address, aligned
    blk_go     = idle_rel && is_blk && wel_q && frame_q.full &&
                 aligned && !blk_prot;
    blk_abort  = idle_rel && is_blk &&
                 !(frame_q.full && aligned && !blk_prot);
    chip_go    = idle_rel && is_chip && wel_q && aligned && !any_prot;
    chip_abort = idle_rel && is_chip && !(aligned && !any_prot);
    wren_go    = idle_rel && is_wren && aligned;
    wrdi_go    = idle_rel && is_wrdi && aligned;
    start      = blk_go || chip_go;
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wel_q <= 1'b0;
    end else if (wren_go) begin
      wel_q <= 1'b1;
    end else if (wrdi_go || blk_abort || chip_abort || start) begin
      // latch cleared on write disable, block or chip abort, or as the erase begins
      wel_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_q <= flash_erase_pkg::ST_IDLE;
      timer_q <= 32'h0000_0000;
      cmd_q   <= '0;
    end else begin
      unique case (state_q)
        flash_erase_pkg::ST_IDLE: begin
          if (blk_go) begin
            state_q      <= flash_erase_pkg::ST_ERASING;
            timer_q      <= erase_cycles(blk_size);
            cmd_q.active <= 1'b1;
            cmd_q.size   <= blk_size;
            cmd_q.base   <= block_base(frame_q.addr, blk_size);
          end else if (chip_go) begin
            state_q      <= flash_erase_pkg::ST_ERASING;
            timer_q      <= erase_cycles(flash_erase_pkg::SIZE_CHIP);
            cmd_q.active <= 1'b1;
            cmd_q.size   <= flash_erase_pkg::SIZE_CHIP;
            cmd_q.base   <= 24'h00_0000;
          end
        end
        flash_erase_pkg::ST_ERASING: begin
          if (timer_q == 32'h0000_0000) begin
            state_q      <= flash_erase_pkg::ST_IDLE;
            cmd_q.active <= 1'b0;
          end else begin
            timer_q <= timer_q - 32'h0000_0001;
          end
        end
      endcase
    end
  end

  // error flag: cleared at start, set on failure
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      epe_q <= 1'b0;
    end else if (state_q == flash_erase_pkg::ST_ERASING && erase_fail_i) begin
      epe_q <= 1'b1;
    end else if (start) begin
      epe_q <= 1'b0;
    end
  end

  // protection bits, all set at reset, set wins
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sector_prot_q <= `SECTOR_PROT_RESET;
    end else begin
      sector_prot_q <= (sector_prot_q & ~prot_clr_i) | prot_set_i;
    end
  end

  assign busy_o                     = cmd_q.active;
  assign write_enable_latch_o       = wel_q;
  assign erase_program_error_flag_o = epe_q;
  assign sector_prot_o              = sector_prot_q;
  assign erase_cmd_o                = cmd_q;

  // ---------------- assertions ----------------

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence s_release;
    rel_q && state_q == flash_erase_pkg::ST_IDLE;
  endsequence

  sequence s_erase_begin;
    state_q == flash_erase_pkg::ST_IDLE ##1
    state_q == flash_erase_pkg::ST_ERASING;
  endsequence

  AST_WREN_SETS: assert property (
    s_release ##0 (is_wren && op_ok && aligned) |=> wel_q)
    else $error("write enable did not set the latch");

  AST_WRDI_CLEARS: assert property (
    s_release ##0 (is_wrdi && op_ok && aligned) |=> !wel_q && !busy_o)
    else $error("write disable did not clear the latch");

  AST_BAD_FRAME_KEEPS: assert property (
    s_release ##0 ((is_wren || is_wrdi) && op_ok && !aligned)
      |=> $stable(wel_q))
    else $error("misaligned enable frame changed the latch");

  AST_NEEDS_LATCH: assert property (
    s_erase_begin |-> $past(wel_q, 1))
    else $error("erase started with latch clear");

  AST_LATCH_DROP_BUSY: assert property (
    s_erase_begin |-> busy_o && !wel_q)
    else $error("erase start not busy or latch still set");

  AST_BLOCK_ABORT: assert property (
    s_release ##0 (is_blk && op_ok && (!frame_q.full || !aligned))
      |=> !wel_q && !busy_o)
    else $error("bad block erase frame did not abort");

  AST_PROTECTED_SKIP: assert property (
    s_release ##0 (is_blk && op_ok && blk_prot) |=> !busy_o)
    else $error("erase ran on a protected sector");

  AST_CHIP_PROTECT: assert property (
    s_release ##0 (is_chip && op_ok && any_prot) |=> !busy_o && !wel_q)
    else $error("chip erase ran with a protected sector");

  AST_BASE_4K: assert property (
    blk_go && blk_size == flash_erase_pkg::SIZE_4K
      |=> erase_cmd_o.base[11:0] == 12'h000 &&
          erase_cmd_o.base[23:12] == $past(frame_q.addr[23:12]))
    else $error("4K erase base not aligned");

  AST_ERR_FLAG: assert property (
    busy_o && erase_fail_i |=> erase_program_error_flag_o)
    else $error("erase failure not flagged");

  AST_TIMER_END: assert property (
    busy_o && timer_q == 32'h0000_0000 |=> !busy_o [*2])
    else $error("erase did not end when timer expired");

  AST_PROT_RESET: assert property (
    disable iff (1'b0)
    !resetn_i |=> sector_prot_o == `SECTOR_PROT_RESET)
    else $error("protection bits not set by reset");

endmodule : flash_erase_seq
`default_nettype wire

// [tb/spi_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// host side of the serial link; the link clock only runs inside frames
module spi_host_model (
  output logic sclk_o, // serial clock, idle low
  output logic cs_n_o, // chip select, active low
  output logic si_o    // serial data towards the device
);
  localparam int HALF = 15; // half of the 30 ns link period

  // idle levels; chip select rises just after time zero so the
  // unreset frame start flag is armed before the first frame
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    si_o   = 1'b0;
    #1 cs_n_o = 1'b1;
  end

  task automatic xfer(input logic [39:0] data, input int nbits);
    cs_n_o = 1'b0;
    for (int k = 0; k < nbits; k++) begin
      si_o = data[39-k]; // msb first, set up a half period early
      #HALF sclk_o = 1'b1;
      #HALF sclk_o = 1'b0;
    end
    #HALF cs_n_o = 1'b1;
    // released data line shows the inverse of the last bit
    si_o = ~si_o;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int N4 = 20;
  localparam int N32 = 30;
  localparam int N64 = 40;
  localparam int NCH = 50;
  localparam int LIMIT = 20000; // far above the whole sequence

  logic        clock = 1'b0;
  logic        resetn;
  logic        sclk, cs_n, si;
  logic        erase_fail;
  logic        busy, write_enable_latch, erase_program_error_flag;
  logic [15:0] prot_set, prot_clr, lockdown, sect_prot;
  flash_erase_pkg::erase_cmd_s cmd_q;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cycles = 0;

  flash_erase_seq #(
    .BLK4_ERASE_CYCLES  (N4),
    .BLK32_ERASE_CYCLES (N32),
    .BLK64_ERASE_CYCLES (N64),
    .CHIP_ERASE_CYCLES  (NCH)
  ) i_flash_erase_seq (
    .clock_i                    (clock),
    .resetn_i                   (resetn),
    .sclk_i                     (sclk),
    .cs_n_i                     (cs_n),
    .si_i                       (si),
    .prot_set_i                 (prot_set),
    .prot_clr_i                 (prot_clr),
    .lockdown_i                 (lockdown),
    .erase_fail_i               (erase_fail),
    .busy_o                     (busy),
    .write_enable_latch_o       (write_enable_latch),
    .erase_program_error_flag_o (erase_program_error_flag),
    .sector_prot_o              (sect_prot),
    .erase_cmd_o                (cmd_q)
  );

  spi_host_model i_spi_host_model (
    .sclk_o (sclk),
    .cs_n_o (cs_n),
    .si_o   (si)
  );

  // 250 MHz system clock
  always #2 clock = ~clock;

  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // a frame that must not start an erase
  task automatic cmd(input logic [39:0] d, input int nb, input logic w);
    i_spi_host_model.xfer(d, nb);
    repeat (12) @(posedge clock);
    #1;
    check(write_enable_latch, w);
    check(busy, 1'b0);
  endtask : cmd

  // a frame that must start an erase; fail injects an array fault
  task automatic erase(input logic [39:0] d, input int nb, input int n,
                       input logic [1:0] sz, input logic [23:0] base,
                       input logic fail);
    int w;
    int len;
    i_spi_host_model.xfer(d, nb);
    w = 0;
    while (busy !== 1'b1 && w < 12) begin
      @(posedge clock);
      #1;
      w++;
    end
    check(busy, 1'b1);
    check(cmd_q.active, 1'b1);
    check(write_enable_latch, 1'b0);
    check(cmd_q.size, sz);
    if (sz != 2'h3) check(cmd_q.base, base);
    len = 0;
    while (busy === 1'b1 && len < 300) begin
      @(posedge clock);
      erase_fail <= fail && len == 2;
      #1;
      len++;
    end
    check(len, n);
    check(cmd_q.active, 1'b0);
    check(erase_program_error_flag, fail);
  endtask : erase

  task automatic prot(input logic [15:0] s, input logic [15:0] c,
                      input logic [15:0] l);
    @(posedge clock);
    prot_set <= s;
    prot_clr <= c;
    lockdown <= l;
    @(posedge clock);
    prot_set <= 16'h0000;
    prot_clr <= 16'h0000;
    @(posedge clock);
    #1;
  endtask : prot

  // main sequence
  initial begin
    resetn = 1'b0;
    prot_set = 16'h0000;
    prot_clr = 16'h0000;
    lockdown = 16'h0000;
    erase_fail = 1'b0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    check(sect_prot, 16'hFFFF);
    check(write_enable_latch, 1'b0);
    check({erase_program_error_flag, cmd_q}, 28'h000_0000);
    cmd(40'h06_0000_0000, 7, 1'b0);
    cmd(40'h06_FF00_0000, 16, 1'b1);
    cmd(40'h04_0000_0000, 12, 1'b1);
    cmd(40'h04_0000_0000, 8, 1'b0);
    prot(16'h0000, 16'hFFFF, 16'h0000);
    check(sect_prot, 16'h0000);
    cmd(40'h20_0100_0000, 32, 1'b0);
    cmd(40'h06_0000_0000, 8, 1'b1);
    erase(40'h20_0ABF_FF00, 32, N4, 2'h0, 24'h0A_B000, 1'b1);
    cmd(40'h06_0000_0000, 8, 1'b1);
    erase(40'h52_03FF_FFA5, 40, N32, 2'h1, 24'h03_8000, 1'b0);
    cmd(40'h06_0000_0000, 8, 1'b1);
    erase(40'hD8_0512_3400, 32, N64, 2'h2, 24'h05_0000, 1'b0);
    cmd(40'h06_0000_0000, 8, 1'b1);
    cmd(40'hD8_0000_0000, 24, 1'b0);
    cmd(40'h06_0000_0000, 8, 1'b1);
    cmd(40'h20_0000_0000, 33, 1'b0);
    prot(16'h0020, 16'h0000, 16'h0100);
    check(sect_prot, 16'h0020);
    cmd(40'h06_0000_0000, 8, 1'b1);
    cmd(40'h20_0500_0000, 32, 1'b0);
    cmd(40'h06_0000_0000, 8, 1'b1);
    cmd(40'h52_0800_0000, 32, 1'b0);
    cmd(40'h06_0000_0000, 8, 1'b1);
    cmd(40'h60_0000_0000, 8, 1'b0);
    prot(16'h0000, 16'h0020, 16'h0000);
    check(sect_prot, 16'h0000);
    cmd(40'h06_0000_0000, 8, 1'b1);
    cmd(40'hC7_0000_0000, 10, 1'b0);
    cmd(40'h60_0000_0000, 8, 1'b0);
    cmd(40'h06_0000_0000, 8, 1'b1);
    erase(40'h60_0000_0000, 8, NCH, 2'h3, 24'h00_0000, 1'b1);
    cmd(40'h06_0000_0000, 8, 1'b1);
    erase(40'hC7_FF00_0000, 16, NCH, 2'h3, 24'h00_0000, 1'b0);
    stop_test();
  end
endmodule : tb
`default_nettype wire
